// *** rtl/core_control_register_bank.sv ***
// Purpose: internal register bank at addresses 0x0A to 0x16
// Assumes: core applies stack push/pop around each access
// Notes: variant selected by parameter
`timescale 1ns/1ps
`include "core_ctrl_cfg.svh"
`default_nettype none
module core_control_register_bank #(
  parameter logic [1:0] VARIANT = 2'h2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // register bus
  input wire core_ctrl_pkg::bus_req_type req,
  output logic [15:0] rdata,
  output logic rd_move_top_only,
  // return stack top page bits and stack moves
  input wire logic rstack_move,
  input wire logic [4:0] rstack_top_page,
  // interrupt controller and timers
  input wire logic [15:0] int_vector,
  input wire logic int_vector_valid,
  input wire logic [47:0] timer_counts,
  input wire logic [3:0] stack_flags_in,
  input wire logic stack_fatal_in,
  output logic timer_irq_clear,
  output logic [2:0] timer_preload_we,
  output logic [15:0] timer_preload,
  // datapath inputs
  input wire logic [15:0] product_low_word,
  input wire core_ctrl_pkg::count_op_type scratch_op,
  input wire logic mac_ext_we,
  input wire logic [15:0] mac_ext_in,
  input wire logic product_low_we,
  input wire logic [15:0] product_low_in,
  // control outputs
  output core_ctrl_pkg::page_out_type pages,
  output logic [3:0] mem_ref_page,
  output logic [15:0] stack_underflow_limits,
  output logic [15:0] stack_overflow_limits,
  output logic [4:0] return_page_index,
  output logic [5:0] vector_base_bits,
  output logic [1:0] timer_clock_sel,
  output logic bus_cycle_stretch,
  output logic round_enable
);
  // ==========================================================
  // decode
  function automatic logic hit(input logic [4:0] a, input logic [4:0] b);
    hit = (a == b);
  endfunction
  wire logic v0 = (VARIANT == `VARIANT_0);
  wire logic v1 = (VARIANT == `VARIANT_1);
  wire logic v2 = (VARIANT == `VARIANT_2);
  wire logic wr = req.wr;
  wire logic rd = req.rd;
  wire logic [15:0] wd = req.wdata;
  wire logic [4:0] ad = req.addr;
  wire logic timer_hit = (ad >= `ADDR_TIMER0) && (ad <= `ADDR_TIMER2);
  wire logic [1:0] timer_idx = 2'(ad - `ADDR_TIMER0);

  // ==========================================================
  // storage
  logic [15:0] underflow;
  logic [15:0] limits;
  logic [15:0] vector_hold;
  logic [4:0] index_page;
  logic [3:0] data_page;
  logic [3:0] user_page;
  logic [3:0] code_page;
  logic [15:0] control;
  logic [15:0] user_base;
  logic [15:0] mac_ext;
  logic [15:0] scratch;

  // variant limit clamp for overflow limits
  function automatic logic [7:0] clamp(input logic [7:0] v);
    clamp = (v1 && v > `LIMIT_MAX_V1) ? `LIMIT_MAX_V1 : v;
  endfunction
  // a byte field covers 0-255, so the 256 ceiling always holds
  wire logic [15:0] next_limits = v0 ? wd : {clamp(wd[15:8]), clamp(wd[7:0])};

  wire logic [15:0] ctrl_mask = v0 ? `CTRL_WR_MASK_V0 : (v1 ? `CTRL_WR_MASK_V1 : `CTRL_WR_MASK_V2);
  wire logic [15:0] next_control = wd & ctrl_mask;
  wire logic [15:0] flag_bits = v0 ? 16'h0000 : {11'h000, stack_flags_in, stack_fatal_in};

  // ==========================================================
  // write strobes
  wire logic underflow_we = wr && hit(ad, `ADDR_UNDERFLOW) && !v0;
  wire logic limits_we = wr && hit(ad, `ADDR_VECTOR);
  wire logic index_we = wr && hit(ad, `ADDR_INDEX);
  wire logic data_page_we = wr && hit(ad, `ADDR_DATA_PAGE);
  wire logic user_page_we = wr && hit(ad, `ADDR_USER_PAGE);
  wire logic code_page_we = wr && hit(ad, `ADDR_CODE_PAGE);
  wire logic control_we = wr && hit(ad, `ADDR_CONTROL);
  wire logic user_base_we = wr && hit(ad, `ADDR_USER_BASE);
  // reserved on variants 0 and 1, so the write is dropped there
  wire logic mac_ext_bus_we = v2 && wr && hit(ad, `ADDR_MAC_EXT);
  // read-only on variant 0
  wire logic scratch_bus_we = !v0 && wr && hit(ad, `ADDR_PRODUCT);
  wire logic scratch_inc = v1 && (scratch_op == core_ctrl_pkg::CNT_INC);
  wire logic scratch_dec = v1 && (scratch_op == core_ctrl_pkg::CNT_DEC);
  wire logic scratch_load = v2 && product_low_we;
  wire logic mac_ext_load = v2 && mac_ext_we;

  // ==========================================================
  // next values
  // a bus write to the index page wins over a stack move in the same cycle
  wire logic index_update = index_we || rstack_move;
  wire logic [4:0] next_index_page = index_we ? wd[4:0] : rstack_top_page;
  wire logic mac_ext_update = mac_ext_bus_we || mac_ext_load;
  wire logic [15:0] next_mac_ext = mac_ext_bus_we ? wd : mac_ext_in;
  // counting wraps through all ones and all zeros by plain modulo arithmetic
  wire logic [15:0] scratch_up = 16'(scratch + 16'h0001);
  wire logic [15:0] scratch_down = 16'(scratch - 16'h0001);
  wire logic scratch_update = scratch_bus_we || scratch_inc || scratch_dec || scratch_load;
  wire logic [15:0] next_scratch = scratch_bus_we ? wd :
    (scratch_inc ? scratch_up : (scratch_dec ? scratch_down : product_low_in));
  // the vector base field replaces the top bits of the controller's vector
  wire logic [15:0] next_vector_hold = {control[`VEC_BASE_MSB:`VEC_BASE_LSB], int_vector[`VEC_BASE_LSB-1:0]};

  // ==========================================================
  // stack limit registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      underflow <= 16'h0000;
    end else if (underflow_we) begin
      underflow <= wd;
    end
  end

  // write-only: a read of this address returns the vector instead
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      limits <= `LIMIT_RESET;
    end else if (limits_we) begin
      limits <= next_limits;
    end
  end

  // ==========================================================
  // vector capture and page registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vector_hold <= `NO_INT_VECTOR;
    end else if (int_vector_valid) begin
      vector_hold <= next_vector_hold;
    end
  end

  // every stack push or pop rewrites the mirror, unless a bus write to the index page comes in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      index_page <= 5'h00;
    end else if (index_update) begin
      index_page <= next_index_page;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      data_page <= 4'h0;
    end else if (data_page_we) begin
      data_page <= wd[3:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      user_page <= 4'h0;
    end else if (user_page_we) begin
      user_page <= wd[3:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      code_page <= 4'h0;
    end else if (code_page_we) begin
      code_page <= wd[3:0];
    end
  end

  // ==========================================================
  // control and datapath registers
  // bits 0-4 never store; they read the live stack flags, or zero on variant 0
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      control <= 16'h0000;
    end else if (control_we) begin
      control <= next_control;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      user_base <= 16'h0000;
    end else if (user_base_we) begin
      user_base <= wd;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mac_ext <= 16'h0000;
    end else if (mac_ext_update) begin
      mac_ext <= next_mac_ext;
    end
  end

  // a bus write overrides a count step in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      scratch <= 16'h0000;
    end else if (scratch_update) begin
      scratch <= next_scratch;
    end
  end

  // ==========================================================
  // read mux, single cycle, zero on reserved
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    if (rd) begin
      unique case (ad)
        `ADDR_UNDERFLOW: next_rdata = v0 ? 16'h0000 : underflow;
        `ADDR_VECTOR: next_rdata = vector_hold;
        `ADDR_INDEX: next_rdata = {11'h000, index_page};
        `ADDR_DATA_PAGE: next_rdata = {12'h000, data_page};
        `ADDR_USER_PAGE: next_rdata = {12'h000, user_page};
        `ADDR_CODE_PAGE: next_rdata = {12'h000, code_page};
        `ADDR_CONTROL: next_rdata = (control & `CTRL_FLAG_KEEP) | flag_bits;
        `ADDR_USER_BASE: next_rdata = user_base;
        `ADDR_MAC_EXT: next_rdata = v2 ? mac_ext : 16'h0000;
        `ADDR_PRODUCT: next_rdata = v0 ? product_low_word : scratch;
        default: next_rdata = timer_hit ? timer_counts[timer_idx*16 +: 16] : 16'h0000;
      endcase
    end
  end

  // data page only when the select bit is set
  wire logic [3:0] next_mem_ref_page = control[`BIT_DATA_SEL] ? data_page : code_page;

  // ==========================================================
  // next values of the outputs
  // variant 0 only: the core moves top into next without pushing next deeper
  wire logic next_rd_move_top_only = v0 && rd && hit(ad, `ADDR_PRODUCT);
  // reading the vector drops every pending timer request one cycle later
  wire logic next_timer_irq_clear = rd && hit(ad, `ADDR_VECTOR);
  wire logic [2:0] next_timer_preload_we = (wr && timer_hit) ? 3'(3'h1 << timer_idx) : 3'h0;
  wire core_ctrl_pkg::page_out_type next_pages = {code_page, data_page, user_page, user_base};
  wire logic [5:0] next_vector_base_bits = control[`VEC_BASE_MSB:`VEC_BASE_LSB];
  wire logic [1:0] next_timer_clock_sel = control[`TIMER_SEL_MSB:`TIMER_SEL_LSB];
  // the rounding bit is reserved on variant 1
  wire logic next_round_enable = !v1 && control[`BIT_ROUND];

  // ==========================================================
  // bus answers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_move_top_only <= 1'b0;
    end else begin
      rd_move_top_only <= next_rd_move_top_only;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timer_irq_clear <= 1'b0;
    end else begin
      timer_irq_clear <= next_timer_irq_clear;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timer_preload_we <= 3'h0;
    end else begin
      timer_preload_we <= next_timer_preload_we;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timer_preload <= 16'h0000;
    end else begin
      timer_preload <= wd;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mem_ref_page <= 4'h0;
    end else begin
      mem_ref_page <= next_mem_ref_page;
    end
  end

  // ==========================================================
  // register-sourced control levels
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pages <= '0;
    end else begin
      pages <= next_pages;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stack_underflow_limits <= 16'h0000;
    end else begin
      stack_underflow_limits <= underflow;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stack_overflow_limits <= `LIMIT_RESET;
    end else begin
      stack_overflow_limits <= limits;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      return_page_index <= 5'h00;
    end else begin
      return_page_index <= index_page;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      vector_base_bits <= 6'h00;
    end else begin
      vector_base_bits <= next_vector_base_bits;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      timer_clock_sel <= 2'h0;
    end else begin
      timer_clock_sel <= next_timer_clock_sel;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bus_cycle_stretch <= 1'b0;
    end else begin
      bus_cycle_stretch <= control[`BIT_STRETCH];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      round_enable <= 1'b0;
    end else begin
      round_enable <= next_round_enable;
    end
  end
endmodule // core_control_register_bank
`default_nettype wire

// *** rtl/core_ctrl_cfg.svh ***
// Purpose: constants for the core control register bank
// Assumes: 16-bit internal register bus, 5-bit register address
// Notes: variant codes 0, 1, 2 select the three product variants
//
// Overview of operation
// - 0x0A underflow limits, reserved on variant 0.
// - 0x0B read returns vector, clears timer requests.
// - vector port holds no-interrupt value after reset.
// - variant 0 write 0x0B loads limits, reset 255.
// - variant 1 overflow limits at most 64; only writes are clamped, reset still loads 255.
// - variant 2 overflow limits at most 256.
// - 5-bit index page mirrors return top bits.
// - index access no stack move; stack moves overwrite.
// - write 0x0C loads index page value.
// - data page used when select bit set.
// - code page for fetches and select clear.
// - user page selects user memory page.
// - control bits 10-15 feed vector bits 10-15.
// - control bits 8-9 select timer clock.
// - bit 7 stretches bus cycles by one.
// - bit 6 rounds product; variant 1 reserved.
// - user base gives 32-word block start.
// - variant 2 0x12 holds accumulator extension.
// - 0x13-0x15 read count, write preload.
// - variant 0 0x16 read-only product, special push.
// - variant 1 0x16 wrapping counter register.
// - variant 2 0x16 read/write product low.
// - single-cycle full 16-bit word access.
// - writes pop stack top into register.
`ifndef CORE_CTRL_CFG_SVH
`define CORE_CTRL_CFG_SVH
`define ADDR_UNDERFLOW 5'h0A
`define ADDR_VECTOR 5'h0B
`define ADDR_INDEX 5'h0C
`define ADDR_DATA_PAGE 5'h0D
`define ADDR_USER_PAGE 5'h0E
`define ADDR_CODE_PAGE 5'h0F
`define ADDR_CONTROL 5'h10
`define ADDR_USER_BASE 5'h11
`define ADDR_MAC_EXT 5'h12
`define ADDR_TIMER0 5'h13
`define ADDR_TIMER1 5'h14
`define ADDR_TIMER2 5'h15
`define ADDR_PRODUCT 5'h16
`define LIMIT_RESET 16'hFFFF
`define LIMIT_MAX_V1 8'h40
`define NO_INT_VECTOR 16'h0000
`define CTRL_WR_MASK_V0 16'hFFE0
`define CTRL_WR_MASK_V1 16'hFFA0
`define CTRL_WR_MASK_V2 16'hFFE0
`define BIT_DATA_SEL 5
`define BIT_ROUND 6
`define BIT_STRETCH 7
`define CTRL_FLAG_KEEP 16'hFFE0
`define VEC_BASE_MSB 15
`define VEC_BASE_LSB 10
`define TIMER_SEL_MSB 9
`define TIMER_SEL_LSB 8
`define VARIANT_0 2'h0
`define VARIANT_1 2'h1
`define VARIANT_2 2'h2
`endif

// *** rtl/core_ctrl_pkg.sv ***
// Purpose: types for the core control register bank
// Assumes: nothing
// Notes: none
package core_ctrl_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } bus_req_type;
  typedef struct packed {
    logic [3:0] code_page;
    logic [3:0] data_page;
    logic [3:0] user_page;
    logic [15:0] user_base;
  } page_out_type;
  typedef enum logic [1:0] {
    CNT_HOLD = 2'b00,
    CNT_INC = 2'b01,
    CNT_DEC = 2'b10
  } count_op_type;
endpackage

// *** verification/core_ctrl_sva.sv ***
// Purpose: assertions on the core control register bank
// Assumes: variant 2, one clock domain
// Notes: derived outputs lag a register write by up to two cycles
`timescale 1ns/1ps
`default_nettype none
module core_ctrl_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // watched ports
  input wire core_ctrl_pkg::bus_req_type req,
  input wire logic [15:0] rdata,
  input wire logic [47:0] timer_counts,
  input wire logic timer_irq_clear,
  input wire logic [2:0] timer_preload_we,
  input wire logic [15:0] timer_preload,
  input wire core_ctrl_pkg::page_out_type pages,
  input wire logic [3:0] mem_ref_page,
  input wire logic [5:0] vector_base_bits,
  input wire logic [1:0] timer_clock_sel,
  input wire logic bus_cycle_stretch
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire rd_vec = req.rd && req.addr == 5'h0B;
  wire wr_tmr = req.wr && req.addr inside {5'h13, 5'h14, 5'h15};
  wire wr_up = req.wr && req.addr == 5'h0E;
  wire wr_ctl = req.wr && req.addr == 5'h10;
  wire [8:0] ctl = {vector_base_bits, timer_clock_sel, bus_cycle_stretch};
  // ==========================================================
  // assertions
  a_vec_read_clear: assert property (rd_vec |=> timer_irq_clear) else $error("no clear");
  a_clear_cause: assert property (timer_irq_clear |-> $past(rd_vec)) else $error("stray clear");
  a_tmr_rd_count: assert property (req.rd && req.addr == 5'h13 |=> rdata == $past(timer_counts[15:0]))
    else $error("bad count");
  a_preload_sel: assert property (wr_tmr |=> timer_preload_we == (3'b001 << ($past(req.addr) - 5'h13))
    && timer_preload == $past(req.wdata)) else $error("bad preload");
  a_preload_cause: assert property (|timer_preload_we |-> $past(wr_tmr)) else $error("stray preload");
  a_idle_rdata_zero: assert property (!req.rd |=> rdata == 16'h0000) else $error("rdata not 0");
  a_user_page_cause: assert property ($changed(pages.user_page) |-> $past(wr_up) || $past(wr_up, 2))
    else $error("stray page");
  a_ctl_bits_cause: assert property ($changed(ctl) |-> $past(wr_ctl) || $past(wr_ctl, 2))
    else $error("stray ctl");
  a_mem_page_src: assert property (wr_ctl |-> ##2 mem_ref_page ==
    ($past(req.wdata[5], 2) ? pages.data_page : pages.code_page)) else $error("bad page");
  c_tmr: cover property (wr_tmr);
  c_vec: cover property (rd_vec);
  c_ctl: cover property (wr_ctl ##2 bus_cycle_stretch);
endmodule // core_ctrl_sva
bind core_control_register_bank core_ctrl_sva u_sva (.mclk, .rst_n, .req, .rdata, .timer_counts,
  .timer_irq_clear, .timer_preload_we, .timer_preload, .pages, .mem_ref_page, .vector_base_bits,
  .timer_clock_sel, .bus_cycle_stretch);
`default_nettype wire

// *** verification/core_model.sv ***
// Purpose: processor core model issuing register bus accesses
// Assumes: requests launched and released on falling edges
// Notes: a stack move sends the inverted low data bits as page
`timescale 1ns/1ps
`default_nettype none
module core_model (
  // clock
  input wire logic mclk,
  // register bus
  output core_ctrl_pkg::bus_req_type req,
  input wire logic [15:0] rdata,
  // return stack
  output logic rstack_move,
  output logic [4:0] rstack_top_page
);
  initial begin
    req = '0;
    rstack_move = 1'b0;
    rstack_top_page = 5'h00;
  end
  // one full word per single-cycle access
  task automatic access(input logic rd, input logic wr, input logic mv, input logic [4:0] a,
    input logic [15:0] d, output logic [15:0] q);
    @(negedge mclk);
    req = '{rd: rd, wr: wr, addr: a, wdata: d};
    rstack_move = mv;
    rstack_top_page = d[4:0] ^ 5'h1F;
    @(negedge mclk);
    q = rdata;
    req = '0;
    rstack_move = 1'b0;
  endtask
endmodule // core_model
`default_nettype wire

// *** verification/tb_top.sv ***
// Purpose: self-checking bench for the core control register bank
// Assumes: variant 2
// Notes: inputs change on falling edges
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, rst_n, ivv, mwe, pwe, fatal;
  logic [15:0] iv, min, pin, q;
  logic [3:0] flags;
  logic [47:0] tc = 48'h3333_2222_1111;
  core_ctrl_pkg::bus_req_type req;
  logic [15:0] rdata, preload, sul, sol;
  logic [2:0] pwe3;
  logic [5:0] vbb;
  logic [1:0] tcs;
  logic [4:0] rpi, rtp;
  logic clr, mv, cyc, rnd;
  logic [3:0] mrp;
  core_ctrl_pkg::page_out_type pages;
  int mismatches = 0;
  int check_count = 0;
  core_model core (.mclk, .req, .rdata, .rstack_move(mv), .rstack_top_page(rtp));
  core_control_register_bank #(.VARIANT(2'h2)) dut (.mclk, .rst_n, .req, .rdata, .rd_move_top_only(),
    .rstack_move(mv), .rstack_top_page(rtp), .int_vector(iv), .int_vector_valid(ivv), .timer_counts(tc),
    .stack_flags_in(flags), .stack_fatal_in(fatal), .timer_irq_clear(clr), .timer_preload_we(pwe3),
    .timer_preload(preload), .product_low_word(16'h0000), .scratch_op(core_ctrl_pkg::CNT_HOLD),
    .mac_ext_we(mwe), .mac_ext_in(min), .product_low_we(pwe), .product_low_in(pin), .pages,
    .mem_ref_page(mrp), .stack_underflow_limits(sul), .stack_overflow_limits(sol), .return_page_index(rpi),
    .vector_base_bits(vbb), .timer_clock_sel(tcs), .bus_cycle_stretch(cyc), .round_enable(rnd));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    core.access(1'b0, 1'b1, 1'b0, a, d, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    core.access(1'b1, 1'b0, 1'b0, a, 16'h0000, q);
    chk(q, e);
  endtask
  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic s_vector;
    rdc(5'h0B, 16'h0000);
    chk(sol, 16'hFFFF);
    pulse(ivv);
    rdc(5'h0B, 16'h0234);
    chk({15'h0, clr}, 16'h0001);
    wr(5'h10, 16'hA800);
    pulse(ivv);
    rdc(5'h0B, 16'hAA34);
  endtask
  task automatic s_control;
    wr(5'h10, 16'hFFFF);
    rdc(5'h10, 16'hFFF5);
    repeat (2) @(negedge mclk);
    chk({vbb, cyc, rnd}, 16'h00FF);
    for (int s = 0; s < 4; s++) begin
      wr(5'h10, 16'(s) << 8);
      repeat (2) @(negedge mclk);
      chk(16'(tcs), 16'(s));
    end
  endtask
  task automatic s_pages;
    wr(5'h0D, 16'h0005);
    wr(5'h0F, 16'h000A);
    wr(5'h0E, 16'h0003);
    wr(5'h11, 16'h1234);
    wr(5'h10, 16'h0000);
    repeat (2) @(negedge mclk);
    chk(16'(mrp), 16'h000A);
    chk({pages.user_page, 12'h000}, 16'h3000);
    chk(pages.user_base, 16'h1234);
    wr(5'h10, 16'h0020);
    repeat (2) @(negedge mclk);
    chk(16'(mrp), 16'h0005);
  endtask
  task automatic s_timers;
    for (int i = 0; i < 3; i++) begin
      wr(5'h13 + 5'(i), 16'hC000 + 16'(i));
      chk({pwe3, preload[12:0]}, {3'b001 << i, 13'(i)});
      rdc(5'h13 + 5'(i), tc[16*i +: 16]);
    end
  endtask
  task automatic s_index_limits;
    core.access(1'b0, 1'b0, 1'b1, 5'h00, 16'h000A, q);
    rdc(5'h0C, 16'h0015);
    core.access(1'b0, 1'b1, 1'b1, 5'h0C, 16'h000A, q);
    repeat (2) @(negedge mclk);
    chk(16'(rpi), 16'h000A);
    wr(5'h0A, 16'h1122);
    wr(5'h0B, 16'h3344);
    rdc(5'h0A, 16'h1122);
    chk(sul, 16'h1122);
    chk(sol, 16'h3344);
  endtask
  task automatic s_datapath;
    wr(5'h12, 16'hBEEF);
    rdc(5'h12, 16'hBEEF);
    wr(5'h16, 16'hC3C3);
    rdc(5'h16, 16'hC3C3);
    pulse(mwe);
    pulse(pwe);
    rdc(5'h12, 16'h5A5A);
    rdc(5'h16, 16'hA5A5);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    {rst_n, ivv, mwe, pwe} = 4'h0;
    {iv, min, pin} = {16'h0234, 16'h5A5A, 16'hA5A5};
    {flags, fatal} = 5'h15;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    s_vector();
    s_control();
    s_pages();
    s_timers();
    s_index_limits();
    s_datapath();
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
